// file: logic/octal_drv_pkg.sv
// Shared constants and types for the octal low-side driver control core
package octal_drv_pkg;

   localparam int NUM_CH     = 8;
   localparam int CMD_W      = 2;
   localparam int WORD_W     = 16;
   localparam int PIN_GROUPS = 4;
   localparam int LIMP_CH    = 4;

   // All command bits set: every channel in off mode
   localparam logic [WORD_W-1:0] CMD_RESET = 16'hffff;
   localparam logic [CMD_W-1:0]  CMD_STANDBY = 2'h0;
   localparam logic [CMD_W-1:0]  CMD_INPUT   = 2'h1;
   localparam logic [CMD_W-1:0]  CMD_ON      = 2'h2;
   localparam logic [CMD_W-1:0]  CMD_OFF     = 2'h3;

   // Frame check: bit count within a byte, and bytes seen (saturating)
   localparam logic [2:0] BIT_IN_BYTE_LAST = 3'h7;
   localparam logic [2:0] BIT_IN_BYTE_ZERO = 3'h0;
   localparam logic [1:0] BYTES_ZERO       = 2'h0;
   localparam logic [1:0] FRAME_MIN_BYTES  = 2'h2;
   localparam logic [1:0] BYTES_SAT        = 2'h3;

   localparam logic TER_RESET = 1'b1;

   // Overload shutdown filter, least time rounds up
   localparam int unsigned CLK_PERIOD_NS     = 50;
   localparam int unsigned OVERLOAD_DELAY_NS = 3000;
   localparam int unsigned OVERLOAD_CYCLES   =
      (OVERLOAD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OVL_CNT_W = 6;
   localparam logic [OVL_CNT_W-1:0] OVL_CNT_ZERO = 6'h00;
   localparam logic [OVL_CNT_W-1:0] OVL_CNT_LAST =
      OVL_CNT_W'(OVERLOAD_CYCLES - 1);

   // Reset values of the input synchronisers
   localparam logic [2:0]  SPI_SYNC_RST  = 3'h2;
   localparam logic [29:0] CTL_SYNC_RST  = 30'h00000000;

   typedef enum logic [1:0] {
      PWR_LOW_Q,
      PWR_NORMAL,
      PWR_LIMP
   } power_state_t;

   typedef struct packed {
      logic open_load;
      logic overload;
      logic over_temp;
   } fault_latch_t;

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic sdi;
   } spi_in_t;

   typedef struct packed {
      logic                    en;
      logic                    limp;
      logic [PIN_GROUPS-1:0]   par;
      logic [NUM_CH-1:0]       ovl;
      logic [NUM_CH-1:0]       hot;
      logic [NUM_CH-1:0]       open;
   } ctl_in_t;

endpackage

// file: logic/pin_filter.sv
// Three-stage input synchroniser that accepts a change once stages agree
`timescale 1ns/1ps
`default_nettype none
module pin_filter #(
   parameter int            W   = 1,
   parameter logic [W-1:0]  RST = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);

   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // First stage feeds only the second, to keep metastability contained
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= RST;
         s2 <= RST;
         s3 <= RST;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Bit by bit, a new level counts only when stages two and three agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= RST;
      end else begin
         for (int b = 0; b < W; b++) begin
            if (s2[b] == s3[b]) begin
               q[b] <= s3[b];
            end
         end
      end
   end

endmodule
`default_nettype wire

// file: logic/octal_drv_core.sv
// Control core of an eight-channel low-side driver with serial command port
//
// Operation
// - Enable rising with limp-home low wakes device into global off.
// - Limp-home rising powers up into limp-home mode, enable ignored.
// - Over-temperature latches off only its own channel.
// - Power-up enters global off with diagnostic sink current off.
// - Fault latches clear on standby, reset, enable low, limp exit.
// - Serial input word holds a two-bit mode per channel.
// - Serial response holds two fault status bits per channel.
// - Words are 16 bits, most significant bit first, both ways.
// - Filtered overcurrent latches channel off until cleared by command.
// - Limp-home ignores serial commands; overload and over-temperature stay detected, readable.
// - Clock count per frame not multiple of 8 or below 16 sets error.
// - Error flag shows on output from select fall to first clock rise.
// - Error flag set on reset exit and on entering global off.
// - A valid frame clears the error flag.
// - Window output is error flag OR serial input, then shift data.
// - Input sampled on clock fall, output updated on clock rise.
// - Command word loads only for valid frame length, else kept.
// - Frame counter armed by select fall, counts clock rises.
// - Modes: 00 standby, 01 parallel input, 10 on, 11 off.
// - Reset sets every command bit, all channels off.
// - Parallel input n drives channels n and n+4 in input mode.
// - Status word of per-channel fault bits goes out after the error flag.
`timescale 1ns/1ps
`default_nettype none
module octal_drv_core
   import octal_drv_pkg::*;
(
   input  wire logic                  MCLK,
   input  wire logic                  RSTN,
   input  wire logic                  EN,
   input  wire logic                  LIMP_HOME_INPUT,
   input  wire logic [PIN_GROUPS-1:0] PARALLEL_DRIVE_INPUT,
   input  wire logic                  SCLK,
   input  wire logic                  CHIP_SELECT_N,
   input  wire logic                  SI,
   input  wire logic [NUM_CH-1:0]     OVERLOAD_SENSE,
   input  wire logic [NUM_CH-1:0]     THERMAL_SENSE,
   input  wire logic [NUM_CH-1:0]     OPEN_LOAD_SENSE,
   output var  logic                  SO,
   output var  logic                  SO_OE,
   output var  logic [NUM_CH-1:0]     CHANNEL_OUTPUT,
   output var  logic [NUM_CH-1:0]     DIAG_CURRENT_EN,
   output var  logic                  TRANSMISSION_ERROR_FLAG,
   output var  logic [1:0]            POWER_STATE
);

   spi_in_t                 spi_raw;
   spi_in_t                 spi;
   ctl_in_t                 ctl_raw;
   ctl_in_t                 ctl;
   power_state_t            state;
   power_state_t            next_state;
   logic                    leave_limp;
   logic                    wake;
   logic                    regs_reset;
   logic                    ter_power_set;
   logic                    sclk_prev;
   logic                    cs_n_prev;
   logic                    cs_fall;
   logic                    cs_rise;
   logic                    sclk_rise;
   logic                    sclk_fall;
   logic [2:0]              bit_in_byte;
   logic [1:0]              bytes;
   logic                    frame_ok;
   logic                    window;
   logic [WORD_W-1:0]       shift;
   logic [WORD_W-1:0]       status_word;
   logic [WORD_W-1:0]       cmd;
   logic                    cmd_load;
   logic                    diag_allowed;
   logic                    transmission_error_flag;
   fault_latch_t            fault     [NUM_CH];
   fault_latch_t            next_fault[NUM_CH];
   logic [OVL_CNT_W-1:0]    ovl_cnt   [NUM_CH];
   logic [NUM_CH-1:0]       next_out;
   logic [NUM_CH-1:0]       next_diag;

   assign spi_raw = '{sclk: SCLK, cs_n: CHIP_SELECT_N, sdi: SI};
   assign ctl_raw = '{en: EN, limp: LIMP_HOME_INPUT,
                      par: PARALLEL_DRIVE_INPUT, ovl: OVERLOAD_SENSE,
                      hot: THERMAL_SENSE, open: OPEN_LOAD_SENSE};

   pin_filter #(.W(3), .RST(SPI_SYNC_RST)) u_spi_filter (
      .clk   (MCLK),
      .rst_n (RSTN),
      .d     (spi_raw),
      .q     (spi)
   );

   pin_filter #(.W(30), .RST(CTL_SYNC_RST)) u_ctl_filter (
      .clk   (MCLK),
      .rst_n (RSTN),
      .d     (ctl_raw),
      .q     (ctl)
   );

   // Power state: limp-home wins, enable alone wakes from low quiescent
   always_comb begin
      next_state = state;
      unique case (state)
         PWR_LOW_Q: begin
            if (ctl.limp) begin
               next_state = PWR_LIMP;
            end else if (ctl.en) begin
               next_state = PWR_NORMAL;
            end
         end
         PWR_NORMAL: begin
            if (ctl.limp) begin
               next_state = PWR_LIMP;
            end else if (!ctl.en) begin
               next_state = PWR_LOW_Q;
            end
         end
         PWR_LIMP: begin
            if (!ctl.limp) begin
               next_state = ctl.en ? PWR_NORMAL : PWR_LOW_Q;
            end
         end
      endcase
   end

   assign leave_limp    = (state == PWR_LIMP) && (next_state != PWR_LIMP);
   assign wake          = (state == PWR_LOW_Q) && (next_state == PWR_NORMAL);
   // Low quiescent holds the command word and fault latches in reset, so the wake path is clean
   assign regs_reset    = leave_limp || wake || (state == PWR_LOW_Q);
   assign ter_power_set = wake || (leave_limp && next_state == PWR_NORMAL);

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         state <= PWR_LOW_Q;
      end else begin
         state <= next_state;
      end
   end

   // Serial edges, found from the filtered pin levels
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         sclk_prev <= 1'b0;
         cs_n_prev <= 1'b1;
      end else begin
         sclk_prev <= spi.sclk;
         cs_n_prev <= spi.cs_n;
      end
   end

   assign cs_fall   = cs_n_prev && !spi.cs_n;
   assign cs_rise   = !cs_n_prev && spi.cs_n;
   assign sclk_rise = !sclk_prev && spi.sclk && !spi.cs_n;
   assign sclk_fall = sclk_prev && !spi.sclk && !spi.cs_n;

   // Frame length: bits within a byte plus saturating byte count
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         bit_in_byte <= BIT_IN_BYTE_ZERO;
         bytes       <= BYTES_ZERO;
      end else if (cs_fall) begin
         bit_in_byte <= BIT_IN_BYTE_ZERO;
         bytes       <= BYTES_ZERO;
      end else if (sclk_rise) begin
         bit_in_byte <= bit_in_byte + 3'h1;
         if (bit_in_byte == BIT_IN_BYTE_LAST && bytes != BYTES_SAT) begin
            bytes <= bytes + 2'h1;
         end
      end
   end

   assign frame_ok = (bit_in_byte == BIT_IN_BYTE_ZERO)
                     && (bytes >= FRAME_MIN_BYTES);

   // Status word: per channel open-load bit above drive-fault bit
   always_comb begin
      status_word = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         status_word[2*i+1] = fault[i].open_load;
         status_word[2*i]   = fault[i].overload
                              || fault[i].over_temp;
      end
   end

   // Shift register: loaded at select fall, input taken on clock fall
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         shift <= '0;
      end else if (cs_fall) begin
         shift <= status_word;
      end else if (sclk_fall) begin
         shift <= {shift[WORD_W-2:0], spi.sdi};
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         window <= 1'b0;
      end else if (cs_fall) begin
         window <= 1'b1;
      end else if (sclk_rise || spi.cs_n) begin
         window <= 1'b0;
      end
   end

   // Output pin: flag OR input in the window, else shifted data on rise
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         SO    <= 1'b0;
         SO_OE <= 1'b0;
      end else begin
         SO_OE <= !spi.cs_n;
         if (sclk_rise) begin
            SO <= shift[WORD_W-1];
         end else if (cs_fall || window) begin
            SO <= transmission_error_flag || spi.sdi;
         end
      end
   end

   // Error flag; any set in the same cycle as a clear wins
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         transmission_error_flag <= TER_RESET;
      end else begin
         if (cs_rise) begin
            transmission_error_flag <= !frame_ok;
         end
         if (ter_power_set) begin
            transmission_error_flag <= 1'b1;
         end
      end
   end

   // Limp-home ignores serial commands; leaving it resets the command word
   assign cmd_load = cs_rise && frame_ok
                     && (state == PWR_NORMAL);

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         cmd          <= CMD_RESET;
         diag_allowed <= 1'b0;
      end else if (regs_reset) begin
         cmd          <= CMD_RESET;
         diag_allowed <= 1'b0;
      end else if (cmd_load) begin
         cmd          <= shift;
         diag_allowed <= 1'b1;
      end
   end

   // Per-channel drive, diagnostic current and fault latch next values
   always_comb begin
      logic [CMD_W-1:0] mode;
      logic             pin;
      logic             drive;
      logic             clr;
      logic             latched;
      mode  = CMD_OFF;
      pin   = 1'b0;
      drive = 1'b0;
      clr   = 1'b0;
      latched = 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
         mode  = cmd[CMD_W*i +: CMD_W];
         pin   = ctl.par[i % PIN_GROUPS];
         drive = 1'b0;
         next_diag[i] = 1'b0;
         if (state == PWR_NORMAL) begin
            unique case (mode)
               CMD_STANDBY: drive = 1'b0;
               CMD_INPUT: begin
                  drive        = pin;
                  next_diag[i] = !pin;
               end
               CMD_ON:      drive = 1'b1;
               CMD_OFF:     next_diag[i] = diag_allowed;
            endcase
         end else if (state == PWR_LIMP) begin
            drive = (i < LIMP_CH) ? pin : 1'b0;
         end
         clr = regs_reset
               || (state == PWR_NORMAL && mode == CMD_STANDBY);
         latched = fault[i].overload || fault[i].over_temp;
         next_out[i] = drive && !latched;
         // Sets come last so a fault arriving with a clear is kept
         next_fault[i].open_load = (fault[i].open_load && !clr)
            || (!CHANNEL_OUTPUT[i] && DIAG_CURRENT_EN[i]
                && ctl.open[i]);
         next_fault[i].overload = (fault[i].overload && !clr)
            || (CHANNEL_OUTPUT[i] && ctl.ovl[i]
                && ovl_cnt[i] == OVL_CNT_LAST);
         next_fault[i].over_temp = (fault[i].over_temp && !clr)
            || ctl.hot[i];
      end
   end

   // Overload filter: current must persist while the channel is on
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         for (int i = 0; i < NUM_CH; i++) begin
            ovl_cnt[i] <= OVL_CNT_ZERO;
         end
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (CHANNEL_OUTPUT[i] && ctl.ovl[i]) begin
               if (ovl_cnt[i] != OVL_CNT_LAST) begin
                  ovl_cnt[i] <= ovl_cnt[i] + 6'h01;
               end
            end else begin
               ovl_cnt[i] <= OVL_CNT_ZERO;
            end
         end
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         for (int i = 0; i < NUM_CH; i++) begin
            fault[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            fault[i] <= next_fault[i];
         end
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         CHANNEL_OUTPUT  <= '0;
         DIAG_CURRENT_EN <= '0;
      end else begin
         CHANNEL_OUTPUT  <= next_out;
         DIAG_CURRENT_EN <= next_diag;
      end
   end

   // Status mirrors for the board: error flag and power state, registered once
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         TRANSMISSION_ERROR_FLAG <= TER_RESET;
         POWER_STATE             <= PWR_LOW_Q;
      end else begin
         TRANSMISSION_ERROR_FLAG <= transmission_error_flag;
         POWER_STATE             <= state;
      end
   end

endmodule
`default_nettype wire

// file: dv/octal_drv_core_sva.sv
// Checker on the ports of the octal driver control core
`timescale 1ns/1ps
`default_nettype none
module octal_drv_core_sva
   import octal_drv_pkg::*;
(
   input wire logic                  MCLK,
   input wire logic                  RSTN,
   input wire logic                  EN,
   input wire logic                  LIMP_HOME_INPUT,
   input wire logic [PIN_GROUPS-1:0] PARALLEL_DRIVE_INPUT,
   input wire logic                  SCLK,
   input wire logic                  CHIP_SELECT_N,
   input wire logic                  SI,
   input wire logic [NUM_CH-1:0]     OVERLOAD_SENSE,
   input wire logic [NUM_CH-1:0]     THERMAL_SENSE,
   input wire logic [NUM_CH-1:0]     OPEN_LOAD_SENSE,
   input wire logic                  SO,
   input wire logic                  SO_OE,
   input wire logic [NUM_CH-1:0]     CHANNEL_OUTPUT,
   input wire logic [NUM_CH-1:0]     DIAG_CURRENT_EN,
   input wire logic                  TRANSMISSION_ERROR_FLAG,
   input wire logic [1:0]            POWER_STATE
);
   logic [7:0] ovl_run;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RSTN);

   // Overload on a driven channel; 60 filter cycles plus pin delay < 72
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         ovl_run <= 8'h00;
      end else if ((CHANNEL_OUTPUT & OVERLOAD_SENSE) == 8'h00) begin
         ovl_run <= 8'h00;
      end else if (ovl_run != 8'hff) begin
         ovl_run <= ovl_run + 8'h01;
      end
   end

   property p_so_oe_on; $fell(CHIP_SELECT_N) |-> ##[3:6] SO_OE; endproperty
   a_so_oe_on: assert property (p_so_oe_on)
      else $error("serial output not enabled after select");
   property p_so_oe_off; CHIP_SELECT_N [*6] |-> !SO_OE; endproperty
   a_so_oe_off: assert property (p_so_oe_off)
      else $error("serial output enabled while deselected");
   property p_window;
      $fell(CHIP_SELECT_N) ##1 (!SCLK && !CHIP_SELECT_N) [*6] ##1
         (!SCLK && !CHIP_SELECT_N && (TRANSMISSION_ERROR_FLAG || SI)) |-> SO;
   endproperty
   a_window: assert property (p_window)
      else $error("flag window output is not flag or input");
   property p_ter_stable;
      (!CHIP_SELECT_N && $stable(POWER_STATE)) [*8]
         |-> $stable(TRANSMISSION_ERROR_FLAG);
   endproperty
   a_ter_stable: assert property (p_ter_stable)
      else $error("error flag moved in mid frame");
   property p_lowq; (POWER_STATE == PWR_LOW_Q) [*3] |-> CHANNEL_OUTPUT == 8'h00
      && DIAG_CURRENT_EN == 8'h00; endproperty
   a_lowq: assert property (p_lowq)
      else $error("channel active in low quiescent state");
   property p_limp;
      (POWER_STATE == PWR_LIMP) [*3] |-> CHANNEL_OUTPUT[7:4] == 4'h0;
   endproperty
   a_limp: assert property (p_limp)
      else $error("upper channel on in limp-home");
   property p_wake;
      POWER_STATE == PWR_NORMAL && $past(POWER_STATE) != PWR_NORMAL
         |-> TRANSMISSION_ERROR_FLAG ##2 DIAG_CURRENT_EN == 8'h00;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake without error flag or with sink current");
   property p_thermal; $rose(|THERMAL_SENSE) ##1 (|THERMAL_SENSE) [*8]
      |-> (CHANNEL_OUTPUT & THERMAL_SENSE) == 8'h00; endproperty
   a_thermal: assert property (p_thermal)
      else $error("hot channel still driven");
   property p_ovl; ovl_run < 8'h48; endproperty
   a_ovl: assert property (p_ovl)
      else $error("overload not shut down in time");

   c_frame: cover property ($rose(CHIP_SELECT_N));
   c_limp: cover property (POWER_STATE == PWR_LIMP);
   c_trip: cover property ($fell(|(CHANNEL_OUTPUT & OVERLOAD_SENSE)));
endmodule

bind octal_drv_core octal_drv_core_sva i_octal_drv_core_sva (
   .MCLK, .RSTN, .EN, .LIMP_HOME_INPUT, .PARALLEL_DRIVE_INPUT, .SCLK,
   .CHIP_SELECT_N, .SI, .OVERLOAD_SENSE, .THERMAL_SENSE, .OPEN_LOAD_SENSE,
   .SO, .SO_OE, .CHANNEL_OUTPUT, .DIAG_CURRENT_EN,
   .TRANSMISSION_ERROR_FLAG, .POWER_STATE
);
`default_nettype wire

// file: dv/spi_master_model.sv
// Serial bus master model standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
   output var  logic SCLK,
   output var  logic CHIP_SELECT_N,
   output var  logic SI,
   input  wire logic SO
);
   initial begin
      SCLK = 1'b0;
      CHIP_SELECT_N = 1'b1;
      SI = 1'b1;
   end

   // One frame of n bits, MSB first; n of 0 only reads the error flag
   task automatic xfer(input int n, input logic [31:0] w,
                       input logic si_win, output logic flag,
                       output logic [31:0] rd);
      rd = 32'h0;
      SI = si_win;
      CHIP_SELECT_N = 1'b0;
      #400;
      flag = SO;
      for (int i = n - 1; i >= 0; i--) begin
         SCLK = 1'b1;
         SI = w[i];
         #200;
         SCLK = 1'b0;
         #200;
         rd[i] = SO;
      end
      CHIP_SELECT_N = 1'b1;
      // Released data line shows the inverse, never the stale value
      SI = ~SI;
      #400;
   endtask
endmodule
`default_nettype wire

// file: dv/test_octal_drv_core.sv
// Self-checking bench for the octal driver control core
`timescale 1ns/1ps
`default_nettype none
module test_octal_drv_core
   import octal_drv_pkg::*;
;
   logic        MCLK, RSTN, EN, LIMP_HOME_INPUT, SCLK, CHIP_SELECT_N, SI;
   logic        SO, SO_OE, TRANSMISSION_ERROR_FLAG, flag, ok;
   logic [3:0]  PARALLEL_DRIVE_INPUT, par;
   logic [7:0]  OVERLOAD_SENSE, THERMAL_SENSE, OPEN_LOAD_SENSE;
   logic [7:0]  CHANNEL_OUTPUT, DIAG_CURRENT_EN;
   logic [1:0]  POWER_STATE;
   logic [18:0] st;
   logic [15:0] rnd, cur;
   logic [31:0] w, rd;
   int          miscompares, n_tests;
   int          lens [6] = '{15, 32, 8, 24, 17, 16};

   octal_drv_core i_octal_drv_core (
      .MCLK, .RSTN, .EN, .LIMP_HOME_INPUT, .PARALLEL_DRIVE_INPUT, .SCLK,
      .CHIP_SELECT_N, .SI, .OVERLOAD_SENSE, .THERMAL_SENSE,
      .OPEN_LOAD_SENSE, .SO, .SO_OE, .CHANNEL_OUTPUT, .DIAG_CURRENT_EN,
      .TRANSMISSION_ERROR_FLAG, .POWER_STATE
   );
   spi_master_model i_spi_master_model (.SCLK, .CHIP_SELECT_N, .SI, .SO);

   assign st = {TRANSMISSION_ERROR_FLAG, POWER_STATE, CHANNEL_OUTPUT,
                DIAG_CURRENT_EN};
   assign PARALLEL_DRIVE_INPUT = par;

   initial begin
      MCLK = 1'b0;
      forever #25 MCLK = ~MCLK;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Expected {outputs, sink currents} once a command has been accepted
   function automatic logic [15:0] drive_of(input logic [15:0] c,
                                            input logic [3:0] p);
      logic [1:0] m;
      drive_of = 16'h0000;
      for (int i = 0; i < NUM_CH; i++) begin
         m = c[2*i +: 2];
         drive_of[8+i] = m == CMD_ON || (m == CMD_INPUT && p[i%4]);
         drive_of[i] = m == CMD_OFF || (m == CMD_INPUT && !p[i%4]);
      end
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(negedge MCLK);
   endtask

   task automatic frame(input int n, input logic [31:0] d);
      i_spi_master_model.xfer(n, d, 1'b0, flag, rd);
      settle(12);
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge MCLK);
      miscompares++;
      complete_run;
   end

   initial begin
      miscompares = 0;
      n_tests = 0;
      rnd = 16'h0001;
      RSTN = 1'b0;
      EN = 1'b0;
      LIMP_HOME_INPUT = 1'b0;
      par = 4'h0;
      OVERLOAD_SENSE = 8'h00;
      THERMAL_SENSE = 8'h00;
      OPEN_LOAD_SENSE = 8'h00;
      settle(3);
      check(st, {1'b1, PWR_LOW_Q, 16'h0000});
      RSTN = 1'b1;
      EN = 1'b1;
      settle(12);
      check(st, {1'b1, PWR_NORMAL, 16'h0000});
      frame(0, 32'h0);
      check(flag, 1'b1);
      for (int k = 0; k < 8; k++) begin
         rnd = lfsr(rnd);
         cur = (k == 0) ? 16'h1b1b : (k == 1) ? 16'he4e4 : rnd;
         par = rnd[3:0] ^ rnd[15:12];
         frame(16, {16'h0000, cur});
         check(rd, 32'h0);
         check(flag, k == 0);
         check(st, {1'b0, PWR_NORMAL, drive_of(cur, par)});
      end
      i_spi_master_model.xfer(16, {16'h0000, cur}, 1'b1, flag, rd);
      check(flag, 1'b1);
      // Odd, short and long frames: only whole bytes of at least two count
      foreach (lens[k]) begin
         rnd = lfsr(rnd);
         w = {rnd, lfsr(rnd)} & ~(32'hffffffff << lens[k]);
         ok = lens[k] % 8 == 0 && lens[k] >= 16;
         frame(lens[k], w);
         if (ok) cur = w[15:0];
         check(st, {!ok, PWR_NORMAL, drive_of(cur, par)});
         if (lens[k] > 16) check(rd[15:0] & ~(16'hffff << (lens[k] - 16)),
                                 w >> 16);
      end
      frame(16, 32'haaaa);
      THERMAL_SENSE = 8'h04;
      settle(12);
      THERMAL_SENSE = 8'h00;
      settle(12);
      check(CHANNEL_OUTPUT, 8'hfb);
      OVERLOAD_SENSE = 8'h10;
      settle(40);
      OVERLOAD_SENSE = 8'h00;
      settle(12);
      check(CHANNEL_OUTPUT, 8'hfb);
      OVERLOAD_SENSE = 8'h10;
      settle(80);
      OVERLOAD_SENSE = 8'h00;
      frame(16, 32'haaaa);
      check(rd, 32'h0110);
      check(CHANNEL_OUTPUT, 8'heb);
      frame(16, 32'ha88a);
      frame(16, 32'haaaa);
      check(rd, 32'h0);
      check(CHANNEL_OUTPUT, 8'hff);
      frame(16, 32'haaab);
      check(DIAG_CURRENT_EN, 8'h01);
      OPEN_LOAD_SENSE = 8'h01;
      settle(12);
      OPEN_LOAD_SENSE = 8'h00;
      frame(16, 32'haaab);
      check(rd, 32'h0002);
      // Input mode with the pin held low long enough for open-load sensing
      par = 4'h0;
      frame(16, 32'haaa8);
      check(rd, 32'h0002);
      frame(16, 32'haaa9);
      check({rd[15:0], DIAG_CURRENT_EN}, {16'h0000, 8'h01});
      OPEN_LOAD_SENSE = 8'h01;
      settle(5100);
      OPEN_LOAD_SENSE = 8'h00;
      frame(16, 32'haaa9);
      check(rd, 32'h0002);
      par = 4'h5;
      LIMP_HOME_INPUT = 1'b1;
      settle(12);
      check({POWER_STATE, CHANNEL_OUTPUT}, {PWR_LIMP, 8'h05});
      frame(16, 32'h0000);
      check(CHANNEL_OUTPUT, 8'h05);
      OVERLOAD_SENSE = 8'h01;
      settle(80);
      OVERLOAD_SENSE = 8'h00;
      frame(16, 32'h0000);
      check({rd[0], CHANNEL_OUTPUT}, {1'b1, 8'h04});
      LIMP_HOME_INPUT = 1'b0;
      settle(12);
      check(st, {1'b1, PWR_NORMAL, 16'h0000});
      frame(16, 32'hffff);
      check(rd, 32'h0);
      EN = 1'b0;
      settle(12);
      check({POWER_STATE, CHANNEL_OUTPUT}, {PWR_LOW_Q, 8'h00});
      EN = 1'b1;
      settle(12);
      check(st, {1'b1, PWR_NORMAL, 16'h0000});
      // Limp-home with enable low, then exit into low quiescent
      EN = 1'b0;
      LIMP_HOME_INPUT = 1'b1;
      settle(12);
      check({POWER_STATE, CHANNEL_OUTPUT}, {PWR_LIMP, 8'h05});
      LIMP_HOME_INPUT = 1'b0;
      settle(12);
      check({POWER_STATE, CHANNEL_OUTPUT}, {PWR_LOW_Q, 8'h00});
      complete_run;
   end
endmodule
`default_nettype wire
